/* File: rtl/mcs_pkg.sv */
package mcs_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [1:0] MCS_IDX_CONTROL = 2'h0;
    localparam logic [1:0] MCS_IDX_SELECT  = 2'h1;
    localparam logic [1:0] MCS_IDX_RESULT  = 2'h2;
    localparam logic [1:0] MCS_IDX_DEBUG   = 2'h3;

    // Field positions.
    localparam int MCS_BIT_ENABLE = 0;
    localparam int MCS_BIT_FAILURE_INTERRUPT_ENABLE  = 1;
    localparam int MCS_BIT_RESET  = 7;
    localparam int MCS_BIT_BUSY   = 0;
    localparam int MCS_BIT_OK     = 1;

    // Section selector encodings.
    localparam logic [1:0] MCS_SRC_FLASH   = 2'h0;
    localparam logic [1:0] MCS_SRC_BOOT_PLUS_APP_CODE = 2'h1;
    localparam logic [1:0] MCS_SRC_BOOT    = 2'h2;

    // Checksum presets and polynomials.
    localparam logic [31:0] MCS_CRC_PRESET = 32'hFFFF_FFFF;
    localparam logic [15:0] MCS_POLY16     = 16'h1021;
    localparam logic [31:0] MCS_POLY32     = 32'h04C1_1DB7;

    // Timing counts.
    localparam logic [1:0] MCS_START_DELAY = 2'h3;
    localparam logic [1:0] MCS_WORD_CYCLES = 2'h3;

    typedef enum logic [3:0] {
        MCS_IDLE  = 4'b0001,
        MCS_DELAY = 4'b0010,
        MCS_FETCH = 4'b0100,
        MCS_DONE  = 4'b1000
    } mcs_state_type;

    // Wishbone classic request.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [3:0]  adr;
        logic [31:0] dat;
    } mcs_wb_req_type;

    // Fuse-derived configuration.
    typedef struct packed {
        logic        crc32;
        logic        startup_scan;
        logic [1:0]  startup_section;
    } mcs_fuse_type;

endpackage

/* File: rtl/mcs_memory_checksum_scanner.sv */
// Chosen here: the Wishbone register port.
`timescale 1ns/100ps
// Behaviour
// - Checksum engine supports CCITT 16-bit and Ethernet 32-bit polynomials.
// - Checksum width comes from the fuse input, never from a register.
// - Running checksum is preset to all ones at every scan start.
// - Bytes processed from section start, MSB first, checksum updated each byte.
// - 16-bit pass needs high byte at end-1, low byte at end.
// - 32-bit checksum: MSB at end, descending to LSB at end-3.
// - Selector picks whole flash, boot plus app, or boot; code three reserved.
// - Scan begins three cycles after enable write; CPU keeps running meanwhile.
// - Active scan owns the flash and stalls the CPU until done.
// - Each fetched 16-bit word takes three clock cycles.
// - Start-up scan runs before CPU release; failure keeps CPU held.
// - A mismatching scan clears the pass flag.
// - Pass flag cleared with interrupt enable raises a sticky NMI request.
// - Interrupt enable set by writing one, cleared only by system reset.
// - Failure interrupt bypasses the CPU global interrupt enable.
// - Sleep freezes scan progress; it resumes on wake.
// - Sleep inside the start delay holds the start until wake.
// - Debugger access suspends; scan restarts on internal access without debugger access.
// - Busy stays one while suspended; internal status reads keep scanner on.
// - While busy, selector and interrupt enable writes are ignored.
// - Debugger pass-zero write may fire NMI; after NMI all writes ignored.
// - Enable stays one after a scan; rewrite one restarts, zero ignored.
// - Reset strobe clears registers a cycle later; idle-only when interrupt enable set.
// - Pass flag reads one before any scan; valid only while not busy.
module mcs_memory_checksum_scanner #(
    parameter int ADDR_W = 17
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_reset,
    input  wire mcs_pkg::mcs_wb_req_type i_wb,
    output logic                        o_wb_ack,
    output logic [31:0]                 o_wb_dat,
    input  wire mcs_pkg::mcs_fuse_type  i_fuse,
    input  wire logic [ADDR_W-1:0]      i_boot_section_last_byte,
    input  wire logic [ADDR_W-1:0]      i_app_code_last_byte,
    input  wire logic [ADDR_W-1:0]      i_flash_last_byte,
    input  wire logic                   i_sleep,
    input  wire logic                   i_debug_access,
    input  wire logic                   i_debug_internal_access,
    input  wire logic                   i_debug_write,
    output logic [ADDR_W-2:0]           o_flash_word_addr,
    output logic                        o_flash_read,
    input  wire logic [15:0]            i_flash_word,
    output logic                        o_cpu_stall,
    output logic                        o_cpu_hold,
    output logic                        o_nmi_request
);
    import mcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Checksum step of one byte, MSB first.

    function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                             input logic [7:0]  b,
                                             input logic        wide);
        logic [31:0] r;
        logic        fb;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (wide) begin
                fb = r[31] ^ b[i];
                r  = {r[30:0], 1'b0} ^ (fb ? MCS_POLY32 : 32'h0000_0000);
            end else begin
                fb = r[15] ^ b[i];
                r  = {16'h0000, r[14:0], 1'b0}
                     ^ {16'h0000, (fb ? MCS_POLY16 : 16'h0000)};
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State.

    mcs_state_type     state;
    mcs_state_type     next_state;
    logic              enable;
    logic              next_enable;
    logic              failure_interrupt_enable;
    logic              next_failure_interrupt_enable;
    logic [1:0]        section;
    logic [1:0]        next_section;
    logic              busy;
    logic              next_busy;
    logic              ok;
    logic              next_ok;
    logic              nmi;
    logic              next_nmi;
    logic              suspended;
    logic              next_suspended;
    logic              boot_scan;
    logic              next_boot_scan;
    logic              boot_pending;
    logic              next_boot_pending;
    logic              reset_pending;
    logic              next_reset_pending;
    logic [1:0]        count;
    logic [1:0]        next_count;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic [31:0]       crc;
    logic [31:0]       next_crc;
    logic              ack;
    logic              next_ack;
    logic [31:0]       rdata;
    logic [31:0]       next_rdata;
    logic [31:0]       stored;
    logic [31:0]       next_stored;
    logic              boot_done_fail;
    logic              next_boot_done_fail;

    logic              access;
    logic              wr;
    logic [7:0]        wbyte;
    logic [ADDR_W-1:0] last_byte;
    logic              hold;
    logic [31:0]       c1;
    logic [31:0]       c2;
    logic [31:0]       residue;

    assign access = i_wb.cyc && i_wb.stb && !ack;
    assign wr     = access && i_wb.we && i_wb.sel[0];
    assign wbyte  = i_wb.dat[7:0];
    // Frozen by sleep or by a debugger access.
    assign hold   = i_sleep || suspended || i_debug_access;

    always_comb begin
        unique case (section)
            MCS_SRC_BOOT_PLUS_APP_CODE: last_byte = i_app_code_last_byte;
            MCS_SRC_BOOT:    last_byte = i_boot_section_last_byte;
            default:         last_byte = i_flash_last_byte;
        endcase
    end

    // For 16-bit, feeding the stored checksum through the engine leaves
    // zero when it matches. For 32-bit the stored bytes sit in reverse
    // order, so they are gathered aside and compared with the running value.
    assign c1 = crc_byte(crc, i_flash_word[15:8], i_fuse.crc32);
    assign c2 = crc_byte(c1, i_flash_word[7:0], i_fuse.crc32);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        next_state         = state;
        next_enable        = enable;
        next_failure_interrupt_enable         = failure_interrupt_enable;
        next_section       = section;
        next_busy          = busy;
        next_ok            = ok;
        next_nmi           = nmi;
        next_suspended     = suspended;
        next_boot_scan     = boot_scan;
        next_boot_pending  = boot_pending;
        next_reset_pending = 1'b0;
        next_count         = count;
        next_addr          = addr;
        next_crc           = crc;
        next_stored        = stored;
        next_ack           = access;
        next_rdata         = 32'h0000_0000;
        residue            = 32'h0000_0000;

        if (i_debug_access && busy) begin
            next_suspended = 1'b1;
        end
        if (i_debug_internal_access && !i_debug_access) begin
            next_suspended = 1'b0;
            // An interrupted fetch starts over from the section's start.
            if (suspended && state == MCS_FETCH) begin
                next_addr   = '0;
                next_count  = 2'h0;
                next_crc    = MCS_CRC_PRESET;
                next_stored = 32'h0000_0000;
            end
        end

        if (boot_pending && i_fuse.startup_scan) begin
            next_boot_pending = 1'b0;
            next_section      = i_fuse.startup_section;
            next_enable       = 1'b1;
            next_busy         = 1'b1;
            next_boot_scan    = 1'b1;
            next_state        = MCS_DELAY;
            next_count        = 2'h0;
        end

        unique case (state)
            MCS_IDLE: begin
            end
            MCS_DELAY: begin
                if (!i_sleep) begin
                    if (count == MCS_START_DELAY - 2'h1) begin
                        next_state = MCS_FETCH;
                        next_count = 2'h0;
                        next_addr  = '0;
                        next_crc   = MCS_CRC_PRESET;
                    end else begin
                        next_count = count + 2'h1;
                    end
                end
            end
            MCS_FETCH: begin
                if (!hold) begin
                    if (count == MCS_WORD_CYCLES - 2'h1) begin
                        next_count = 2'h0;
                        next_addr  = ADDR_W'(addr + ADDR_W'(2));
                        if (i_fuse.crc32
                            && addr + ADDR_W'(3) >= last_byte) begin
                            next_stored = {i_flash_word[7:0],
                                           i_flash_word[15:8],
                                           stored[31:16]};
                        end else begin
                            next_crc = c2;
                        end
                        if (addr + ADDR_W'(1) >= last_byte) begin
                            next_state = MCS_DONE;
                        end
                    end else begin
                        next_count = count + 2'h1;
                    end
                end
            end
            MCS_DONE: begin
                residue = i_fuse.crc32 ? (crc ^ stored)
                                       : {16'h0000, crc[15:0]};
                next_ok    = (residue == 32'h0000_0000);
                next_busy  = 1'b0;
                next_state = MCS_IDLE;
                next_boot_scan = 1'b0;
                if (residue != 32'h0000_0000 && failure_interrupt_enable) begin
                    next_nmi = 1'b1;
                end
            end
            default: next_state = MCS_IDLE;
        endcase

        if (wr && !nmi) begin
            unique case (i_wb.adr[3:2])
                MCS_IDX_CONTROL: begin
                    if (wbyte[MCS_BIT_FAILURE_INTERRUPT_ENABLE] && !busy) begin
                        next_failure_interrupt_enable = 1'b1;
                    end
                    if (wbyte[MCS_BIT_ENABLE]) begin
                        next_enable = 1'b1;
                        next_busy   = 1'b1;
                        next_state  = MCS_DELAY;
                        next_count  = 2'h0;
                    end
                    if (wbyte[MCS_BIT_RESET] && (!failure_interrupt_enable || !busy)) begin
                        next_reset_pending = 1'b1;
                    end
                end
                MCS_IDX_SELECT: begin
                    if (!busy) begin
                        next_section = wbyte[1:0];
                    end
                end
                MCS_IDX_RESULT: begin
                    if (i_debug_write) begin
                        if (!wbyte[MCS_BIT_BUSY]) begin
                            next_busy      = 1'b0;
                            next_state     = MCS_IDLE;
                            next_suspended = 1'b0;
                        end else if (!busy) begin
                            next_busy  = 1'b1;
                            next_state = MCS_DELAY;
                            next_count = 2'h0;
                        end
                        next_ok = wbyte[MCS_BIT_OK];
                        if (!wbyte[MCS_BIT_OK] && failure_interrupt_enable) begin
                            next_nmi = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        if (reset_pending) begin
            next_enable  = 1'b0;
            next_section = MCS_SRC_FLASH;
            next_busy    = 1'b0;
            next_ok      = 1'b1;
            next_state   = MCS_IDLE;
            next_suspended = 1'b0;
        end
        // An NMI request already raised is never lost to a clear.
        if (nmi) begin
            next_nmi = 1'b1;
        end

        if (access && !i_wb.we) begin
            unique case (i_wb.adr[3:2])
                MCS_IDX_CONTROL: begin
                    next_rdata[MCS_BIT_ENABLE] = enable;
                    next_rdata[MCS_BIT_FAILURE_INTERRUPT_ENABLE]  = failure_interrupt_enable;
                end
                MCS_IDX_SELECT: next_rdata[1:0] = section;
                MCS_IDX_RESULT: begin
                    next_rdata[MCS_BIT_BUSY] = busy;
                    next_rdata[MCS_BIT_OK]   = ok;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state         <= MCS_IDLE;
            enable        <= 1'b0;
            failure_interrupt_enable         <= 1'b0;
            section       <= MCS_SRC_FLASH;
            busy          <= 1'b0;
            ok            <= 1'b1;
            nmi           <= 1'b0;
            suspended     <= 1'b0;
            boot_scan     <= 1'b0;
            boot_pending  <= 1'b1;
            reset_pending <= 1'b0;
            count         <= 2'h0;
            addr          <= '0;
            crc           <= MCS_CRC_PRESET;
            stored        <= 32'h0000_0000;
            ack           <= 1'b0;
            rdata         <= 32'h0000_0000;
        end else begin
            state         <= next_state;
            enable        <= next_enable;
            failure_interrupt_enable         <= next_failure_interrupt_enable;
            section       <= next_section;
            busy          <= next_busy;
            ok            <= next_ok;
            nmi           <= next_nmi;
            suspended     <= next_suspended;
            boot_scan     <= next_boot_scan;
            boot_pending  <= next_boot_pending && i_fuse.startup_scan;
            reset_pending <= next_reset_pending;
            count         <= next_count;
            addr          <= next_addr;
            crc           <= next_crc;
            stored        <= next_stored;
            ack           <= next_ack;
            rdata         <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign o_wb_ack          = ack;
    assign o_wb_dat          = rdata;
    assign o_flash_word_addr = addr[ADDR_W-1:1];
    assign o_flash_read      = (state == MCS_FETCH) && !hold;
    assign o_cpu_stall       = (state == MCS_FETCH) || (state == MCS_DONE);
    // A failed start-up scan keeps the CPU from running until reset.
    assign o_cpu_hold        = boot_pending || boot_scan
                               || boot_done_fail;
    assign o_nmi_request     = nmi;

    always_comb begin
        next_boot_done_fail = boot_done_fail;
        if (boot_scan && state == MCS_DONE && next_ok == 1'b0) begin
            next_boot_done_fail = 1'b1;
        end
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            boot_done_fail <= 1'b0;
        end else begin
            boot_done_fail <= next_boot_done_fail;
        end
    end

endmodule

/* File: testbench/mcs_memory_checksum_scanner_assertions.sv */
`timescale 1ns/100ps
module mcs_scanner_checker #(
    parameter int ADDR_W = 17
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_reset,
    input  wire mcs_pkg::mcs_wb_req_type i_wb,
    input  wire logic                    o_wb_ack,
    input  wire mcs_pkg::mcs_fuse_type   i_fuse,
    input  wire logic                    i_sleep,
    input  wire logic                    i_debug_access,
    input  wire logic                    i_debug_internal_access,
    input  wire logic [ADDR_W-2:0]       o_flash_word_addr,
    input  wire logic                    o_flash_read,
    input  wire logic                    o_cpu_stall,
    input  wire logic                    o_cpu_hold,
    input  wire logic                    o_nmi_request
);
    import mcs_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    logic enable_taken;
    assign enable_taken = i_wb.cyc && i_wb.stb && i_wb.we && !o_wb_ack
        && i_wb.adr[3:2] == MCS_IDX_CONTROL && i_wb.sel[0]
        && i_wb.dat[MCS_BIT_ENABLE] && !i_wb.dat[MCS_BIT_RESET]
        && !o_cpu_stall && !o_nmi_request && !i_sleep && !i_debug_access;

    read_when_stall_a: assert property (o_flash_read |-> o_cpu_stall)
        else $error("flash read without cpu stall");
    sleep_freeze_a: assert property (i_sleep |-> !o_flash_read)
        else $error("flash read during sleep");
    debug_freeze_a: assert property (i_debug_access |-> !o_flash_read)
        else $error("flash read during debugger access");
    nmi_sticky_a: assert property (o_nmi_request |=> o_nmi_request)
        else $error("nmi request dropped without reset");
    nmi_cause_a: assert property ($rose(o_nmi_request) |->
        $past(o_cpu_stall) || $past(o_wb_ack) || o_wb_ack)
        else $error("nmi request without scan end or write");
    start_delay_a: assert property (enable_taken |=>
        !o_flash_read [*3] ##1 o_flash_read)
        else $error("scan start not three cycles after enable");
    word_hold_a: assert property ((o_flash_read
        && $changed(o_flash_word_addr) && !i_debug_internal_access)
        |=> $stable(o_flash_word_addr) [*2])
        else $error("flash word held under three cycles");
    hold_release_a: assert property (!i_fuse.startup_scan |=> !o_cpu_hold)
        else $error("cpu held without start-up scan");

    cover property (enable_taken);
    cover property ($rose(o_nmi_request));
    cover property (i_sleep && o_cpu_stall);
    cover property ($fell(o_cpu_hold) && i_fuse.startup_scan);
endmodule

bind mcs_memory_checksum_scanner mcs_scanner_checker #(.ADDR_W(ADDR_W))
    u_checker (.i_clk(i_clk), .i_reset(i_reset), .i_wb(i_wb),
    .o_wb_ack(o_wb_ack), .i_fuse(i_fuse), .i_sleep(i_sleep),
    .i_debug_access(i_debug_access),
    .i_debug_internal_access(i_debug_internal_access),
    .o_flash_word_addr(o_flash_word_addr), .o_flash_read(o_flash_read),
    .o_cpu_stall(o_cpu_stall), .o_cpu_hold(o_cpu_hold),
    .o_nmi_request(o_nmi_request));

/* File: testbench/mcs_flash_model.sv */
`timescale 1ns/100ps
module mcs_flash_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_word_addr,
    input  wire logic        i_read,
    output logic      [15:0] o_word
);
    logic [7:0]  mem [0:63];
    logic [15:0] last = 16'h0000;
    // A released bus shows the inverse of the last word, never a stale copy.
    always_comb begin
        if (i_read) begin
            o_word = {mem[{i_word_addr[4:0], 1'b0}],
                      mem[{i_word_addr[4:0], 1'b1}]};
        end else begin
            o_word = ~last;
        end
    end
    always @(posedge i_clk) begin
        if (i_read) begin
            last <= o_word;
        end
    end
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/100ps
module tb;
    import mcs_pkg::*;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    mcs_wb_req_type wb = '0;
    mcs_fuse_type   fuse = '0;
    logic           sleep = 1'b0;
    logic           dbg = 1'b0;
    logic           dbg_int = 1'b0;
    logic           dbg_wr = 1'b0;
    logic           ack;
    logic [31:0]    rdat;
    logic [15:0]    faddr;
    logic           fread;
    logic [15:0]    fword;
    logic           stall;
    logic           hold;
    logic           nmi;
    logic [31:0]    seen;
    int             num_errors = 0;
    int             cmp_count = 0;
    int             cycles = 0;

    always #5 clk = ~clk;

    mcs_memory_checksum_scanner #(.ADDR_W(17)) i_mcs_memory_checksum_scanner (
        .i_clk(clk), .i_reset(rst), .i_wb(wb), .o_wb_ack(ack),
        .o_wb_dat(rdat), .i_fuse(fuse),
        .i_boot_section_last_byte(17'h0_000F),
        .i_app_code_last_byte(17'h0_001F), .i_flash_last_byte(17'h0_003F),
        .i_sleep(sleep), .i_debug_access(dbg),
        .i_debug_internal_access(dbg_int), .i_debug_write(dbg_wr),
        .o_flash_word_addr(faddr), .o_flash_read(fread),
        .i_flash_word(fword), .o_cpu_stall(stall), .o_cpu_hold(hold),
        .o_nmi_request(nmi));
    mcs_flash_model flash_model (.i_clk(clk), .i_word_addr(faddr),
        .i_read(fread), .o_word(fword));

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic [3:0] adr, input logic we,
                       input logic [7:0] d);
        @(posedge clk);
        wb <= '{1'b1, 1'b1, we, 4'h1, adr, {24'h00_0000, d}};
        do @(posedge clk); while (ack !== 1'b1);
        seen = rdat;
        wb <= '0;
    endtask

    task automatic rd(input logic [3:0] adr, input logic [31:0] exp,
                      input string what);
        bus(adr, 1'b0, 8'h00);
        check(what, seen, exp);
    endtask

    task automatic wait_idle;
        do bus(4'h8, 1'b0, 8'h00); while (seen[MCS_BIT_BUSY] !== 1'b0);
    endtask

    task automatic do_reset(input mcs_fuse_type f);
        @(posedge clk);
        fuse <= f;
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
    endtask

    // Fills the image and stores the checksum of all bytes before it.
    task automatic build(input int e, input bit wide);
        logic [31:0] c;
        logic        fb;
        int          n;
        for (int k = 0; k < 64; k++) flash_model.mem[k] = 8'(k * 37 + 5);
        n = wide ? e - 3 : e - 1;
        c = MCS_CRC_PRESET;
        for (int k = 0; k < n; k++) begin
            for (int b = 7; b >= 0; b--) begin
                fb = flash_model.mem[k][b] ^ (wide ? c[31] : c[15]);
                c = c << 1;
                if (fb) c = c ^ (wide ? MCS_POLY32 : {16'h0000, MCS_POLY16});
            end
        end
        if (wide) begin
            {flash_model.mem[e], flash_model.mem[e-1]} = c[31:16];
            {flash_model.mem[e-2], flash_model.mem[e-3]} = c[15:0];
        end else begin
            {flash_model.mem[e-1], flash_model.mem[e]} = c[15:0];
        end
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset('0);
        rd(4'h0, 32'h0000_0000, "control reset");
        rd(4'h4, 32'h0000_0000, "select reset");
        rd(4'h8, 32'h0000_0002, "result reset");
        rd(4'hC, 32'h0000_0000, "unmapped");
        for (int s = 0; s < 3; s++) begin
            build(s == 0 ? 63 : (s == 1 ? 31 : 15), 1'b0);
            bus(4'h4, 1'b1, 8'(s));
            bus(4'h0, 1'b1, 8'h01);
            wait_idle;
            check("crc16 result", seen, 32'h0000_0002);
            rd(4'h0, 32'h0000_0001, "enable kept");
            bus(4'h0, 1'b1, 8'h00);
            rd(4'h0, 32'h0000_0001, "enable zero ignored");
            rd(4'h4, 32'(s), "select");
        end
        build(63, 1'b0);
        bus(4'h4, 1'b1, 8'h00);
        bus(4'h0, 1'b1, 8'h01);
        bus(4'h4, 1'b1, 8'h02);
        bus(4'h0, 1'b1, 8'h03);
        repeat (6) @(posedge clk);
        check("cpu stall", 32'(stall), 32'h0000_0001);
        sleep <= 1'b1;
        repeat (10) @(posedge clk);
        check("read in sleep", 32'(fread), 32'h0000_0000);
        sleep <= 1'b0;
        dbg <= 1'b1;
        rd(4'h8, 32'h0000_0003, "busy while suspended");
        repeat (6) @(posedge clk);
        dbg <= 1'b0;
        dbg_int <= 1'b1;
        @(posedge clk);
        dbg_int <= 1'b0;
        wait_idle;
        check("resumed result", seen, 32'h0000_0002);
        rd(4'h4, 32'h0000_0000, "select locked busy");
        rd(4'h0, 32'h0000_0001, "failure_interrupt_enable locked busy");
        bus(4'h0, 1'b1, 8'h02);
        flash_model.mem[5] = ~flash_model.mem[5];
        bus(4'h0, 1'b1, 8'h01);
        wait_idle;
        check("fail result", seen, 32'h0000_0000);
        check("nmi", 32'(nmi), 32'h0000_0001);
        bus(4'h4, 1'b1, 8'h01);
        bus(4'h0, 1'b1, 8'h80);
        rd(4'h4, 32'h0000_0000, "select after nmi");
        rd(4'h0, 32'h0000_0003, "control after nmi");
        build(15, 1'b1);
        do_reset('{1'b1, 1'b1, MCS_SRC_BOOT});
        while (hold !== 1'b0) @(posedge clk);
        rd(4'h0, 32'h0000_0001, "startup enable");
        rd(4'h4, 32'h0000_0002, "startup select");
        rd(4'h8, 32'h0000_0002, "crc32 result");
        bus(4'h0, 1'b1, 8'h80);
        rd(4'h0, 32'h0000_0000, "strobe control");
        rd(4'h4, 32'h0000_0000, "strobe select");
        dbg_wr <= 1'b1;
        bus(4'h8, 1'b1, 8'h00);
        rd(4'h8, 32'h0000_0000, "debug ok zero");
        bus(4'h4, 1'b1, 8'h02);
        bus(4'h8, 1'b1, 8'h01);
        bus(4'h8, 1'b1, 8'h02);
        rd(4'h8, 32'h0000_0002, "debug cancel");
        bus(4'h8, 1'b1, 8'h01);
        wait_idle;
        check("debug scan", seen, 32'h0000_0002);
        dbg_wr <= 1'b0;
        flash_model.mem[2] = ~flash_model.mem[2];
        do_reset('{1'b1, 1'b1, MCS_SRC_BOOT});
        wait_idle;
        check("startup fail", seen, 32'h0000_0000);
        check("cpu held", 32'(hold), 32'h0000_0001);
        complete_run;
    end
endmodule
